// *** verilog/cdcr_pkg.sv ***
// Package for the cursor and DAC control register bank
package cdcr_pkg;
  // Indirect register indices
  localparam logic [7:0] CURSOR_CONTROL_INDIRECT_IDX = 8'h06;
  localparam logic [7:0] MISC_OUTPUT_CONTROL_IDX     = 8'h1E;
  // Direct register select code
  localparam logic [3:0] CURSOR_CONTROL_DIRECT_SEL   = 4'h9;
  // Reset values
  localparam logic [7:0] CURSOR_CONTROL_INDIRECT_RST = 8'h00;
  localparam logic [7:0] MISC_OUTPUT_CONTROL_RST     = 8'h00;
  localparam logic [7:0] CURSOR_CONTROL_DIRECT_RST   = 8'h00;
  // Writable bit masks (reserved bits stay zero)
  localparam logic [7:0] MISC_WRITE_MASK             = 8'h29;
  localparam logic [7:0] DIRECT_WRITE_MASK           = 8'h03;
  // Misc register fields
  localparam int MISC_BYPASS_BIT    = 5;
  localparam int MISC_RES_BIT       = 3;
  localparam int MISC_PWRDN_BIT     = 0;
  // Indirect cursor register fields
  localparam int CCI_SELECT_BIT     = 7;
  localparam int CCI_FIELD_INV_BIT  = 6;
  localparam int CCI_INTERLACE_BIT  = 5;
  localparam int CCI_VBLANK_LEN_BIT = 4;
  localparam int CCI_ADDR9_BIT      = 3;
  localparam int CCI_ADDR8_BIT      = 2;
  // Vertical blank detection lengths in dot clocks
  localparam logic [12:0] VBLANK_SHORT_CYC = 13'h0800;
  localparam logic [12:0] VBLANK_LONG_CYC  = 13'h1000;
  // Cursor formats
  typedef enum logic [1:0] {
    CDCR_CURSOR_OFF    = 2'h0,
    CDCR_CURSOR_THREE  = 2'h1,
    CDCR_CURSOR_GFX2   = 2'h2,
    CDCR_CURSOR_WINSYS = 2'h3
  } cdcr_cursor_mode_t;
endpackage

// *** verilog/cdcr_regs.sv ***
// Cursor and DAC control register bank with vertical blank detector
// Functional notes
// - Bypass bit clear feeds palette RAM to the DACs, set feeds the direct-color delay path.
// - Bypass is taken when the bypass bit OR the color-key result asks for it.
// - On the palette path, lookup data comes from the legacy or the pixel port.
// - Resolution bit clear means 6-bit, set means 8-bit for DACs and palette.
// - Power-down bit set powers the DACs down; clear keeps them running.
// - Select bit clear uses the indirect cursor mode, set uses the direct one.
// - Interlace enable runs the cursor interlaced, using the field input per the invert bit.
// - Vertical blank is declared after 2048 or 4096 dot clocks with no blank rising edge.
// - Two indirect bits give cursor RAM address bits 9 and 8 above the direct low byte.
// - Cursor mode 00 off, 01 three-color, 10 second standard, 11 window-system.
// - Direct register holds an alternate two-bit mode; its upper six bits read zero.
// - Misc register resets to zero.
// - Both cursor registers reset to zero.
// - Registers are reached over the 8-bit port by select lines or by index.
`timescale 1ns/100ps
module cdcr_regs
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  // 8-bit microprocessor port
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       indirect_i,
  input  wire logic [3:0] reg_sel_i,
  input  wire logic [7:0] index_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // Video side
  input  wire logic       colorkey_bypass_i,
  input  wire logic       pixel_port_sel_i,
  input  wire logic       odd_even_i,
  input  wire logic       blank_i,
  input  wire logic [7:0] cursor_ram_addr_lo_i,
  // Controls
  output logic            bypass_sel_o,
  output logic            pixel_port_path_o,
  output logic            dac_8bit_o,
  output logic            dac_powerdown_o,
  output logic      [1:0] cursor_mode_o,
  output logic            interlace_en_o,
  output logic            odd_field_o,
  output logic      [9:0] cursor_ram_addr_o,
  output logic            vblank_o
);

  logic [7:0]  misc_q, misc_d;
  logic [7:0]  cci_q, cci_d;
  logic [7:0]  ccd_q, ccd_d;
  logic [7:0]  rdata_d;
  logic        blank_q, blank_d;
  logic [12:0] run_q, run_d;
  logic        vblank_d;
  logic        bypass_d, ppath_d, res_d, pwr_d, il_d, odd_d;
  logic [1:0]  mode_d;
  logic [9:0]  addr_d;

  // True when the indirect map points at the given index
  function automatic logic hit_idx(input logic [7:0] idx);
    return indirect_i && (index_i == idx);
  endfunction

  // Host writes land at the enabled edge; reads return the value held before it
  always_comb
  begin
    misc_d  = misc_q;
    cci_d   = cci_q;
    ccd_d   = ccd_q;
    rdata_d = rdata_o;
    // Access by index or by direct select code
    if (wr_i)
    begin
      if (hit_idx(cdcr_pkg::MISC_OUTPUT_CONTROL_IDX))
        misc_d = wdata_i & cdcr_pkg::MISC_WRITE_MASK;
      if (hit_idx(cdcr_pkg::CURSOR_CONTROL_INDIRECT_IDX))
        cci_d = wdata_i;
      if (!indirect_i && reg_sel_i == cdcr_pkg::CURSOR_CONTROL_DIRECT_SEL)
        ccd_d = wdata_i & cdcr_pkg::DIRECT_WRITE_MASK;
    end
    // Unmapped reads give zero so probing software sees a quiet bus
    if (rd_i)
    begin
      rdata_d = 8'h00;
      if (hit_idx(cdcr_pkg::MISC_OUTPUT_CONTROL_IDX))
        rdata_d = misc_q;
      else if (hit_idx(cdcr_pkg::CURSOR_CONTROL_INDIRECT_IDX))
        rdata_d = cci_q;
      else if (!indirect_i && reg_sel_i == cdcr_pkg::CURSOR_CONTROL_DIRECT_SEL)
        rdata_d = ccd_q;
    end
  end

  always_comb
  begin
    blank_d = blank_i;
    // Counts dot clocks since the last blank rising edge, saturating
    // Saturation keeps vblank up through long blank-free stretches instead of wrapping
    if (blank_i && !blank_q)
      run_d = 13'h0000;
    else if (run_q != cdcr_pkg::VBLANK_LONG_CYC)
      run_d = run_q + 13'h0001;
    else
      run_d = run_q;
    vblank_d = cci_q[cdcr_pkg::CCI_VBLANK_LEN_BIT]
             ? (run_d >= cdcr_pkg::VBLANK_LONG_CYC)
             : (run_d >= cdcr_pkg::VBLANK_SHORT_CYC);
  end

  always_comb
  begin
    // Bypass also drops the pixel-port path, as palette data is then unused
    bypass_d = misc_q[cdcr_pkg::MISC_BYPASS_BIT] | colorkey_bypass_i;
    ppath_d  = pixel_port_sel_i & ~bypass_d;
    res_d    = misc_q[cdcr_pkg::MISC_RES_BIT];
    pwr_d    = misc_q[cdcr_pkg::MISC_PWRDN_BIT];
    mode_d   = cci_q[cdcr_pkg::CCI_SELECT_BIT] ? ccd_q[1:0] : cci_q[1:0];
    il_d     = cci_q[cdcr_pkg::CCI_INTERLACE_BIT];
    odd_d    = odd_even_i ^ cci_q[cdcr_pkg::CCI_FIELD_INV_BIT];
    addr_d   = {cci_q[cdcr_pkg::CCI_ADDR9_BIT], cci_q[cdcr_pkg::CCI_ADDR8_BIT],
                cursor_ram_addr_lo_i};
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      misc_q            <= cdcr_pkg::MISC_OUTPUT_CONTROL_RST;
      cci_q             <= cdcr_pkg::CURSOR_CONTROL_INDIRECT_RST;
      ccd_q             <= cdcr_pkg::CURSOR_CONTROL_DIRECT_RST;
      rdata_o           <= 8'h00;
      blank_q           <= 1'b0;
      run_q             <= 13'h0000;
      vblank_o          <= 1'b0;
      bypass_sel_o      <= 1'b0;
      pixel_port_path_o <= 1'b0;
      dac_8bit_o        <= 1'b0;
      dac_powerdown_o   <= 1'b0;
      cursor_mode_o     <= 2'h0;
      interlace_en_o    <= 1'b0;
      odd_field_o       <= 1'b0;
      cursor_ram_addr_o <= 10'h000;
    end
    // Enable low holds every register, outputs included
    else if (clk_en_i)
    begin
      misc_q            <= misc_d;
      cci_q             <= cci_d;
      ccd_q             <= ccd_d;
      rdata_o           <= rdata_d;
      blank_q           <= blank_d;
      run_q             <= run_d;
      vblank_o          <= vblank_d;
      bypass_sel_o      <= bypass_d;
      pixel_port_path_o <= ppath_d;
      dac_8bit_o        <= res_d;
      dac_powerdown_o   <= pwr_d;
      cursor_mode_o     <= mode_d;
      interlace_en_o    <= il_d;
      odd_field_o       <= odd_d;
      cursor_ram_addr_o <= addr_d;
    end
  end

  a_bypass_or: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> bypass_sel_o == ($past(misc_q[5]) | $past(colorkey_bypass_i)))
    else $error("bypass select mismatch");
  a_mode_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> cursor_mode_o == ($past(cci_q[7]) ? $past(ccd_q[1:0]) : $past(cci_q[1:0])))
    else $error("cursor mode source wrong");
  a_field_sense: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> odd_field_o == ($past(odd_even_i) ^ $past(cci_q[6])))
    else $error("field sense wrong");
  a_vblank_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && blank_i && !blank_q) |=> !vblank_o)
    else $error("vblank after blank edge");
  a_direct_rsvd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ccd_q[7:2] == 6'h00)
    else $error("direct reserved bits set");
  a_misc_rsvd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (misc_q & ~cdcr_pkg::MISC_WRITE_MASK) == 8'h00)
    else $error("misc reserved bits set");
  a_addr_concat: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> cursor_ram_addr_o == {$past(cci_q[3:2]), $past(cursor_ram_addr_lo_i)})
    else $error("cursor address wrong");
  a_power_res: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> (dac_powerdown_o == $past(misc_q[0])) && (dac_8bit_o == $past(misc_q[3])))
    else $error("dac control wrong");
  a_pixel_path: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> pixel_port_path_o == ($past(pixel_port_sel_i) & ~bypass_sel_o))
    else $error("pixel path select wrong");
  a_interlace_en: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i |=> interlace_en_o == $past(cci_q[cdcr_pkg::CCI_INTERLACE_BIT]))
    else $error("interlace enable wrong");

  // Write and read paths of the host port
  a_misc_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && wr_i && indirect_i && index_i == cdcr_pkg::MISC_OUTPUT_CONTROL_IDX)
    |=> misc_q == ($past(wdata_i) & cdcr_pkg::MISC_WRITE_MASK))
    else $error("misc write lost");
  a_direct_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && wr_i && !indirect_i
     && reg_sel_i == cdcr_pkg::CURSOR_CONTROL_DIRECT_SEL)
    |=> ccd_q == ($past(wdata_i) & cdcr_pkg::DIRECT_WRITE_MASK))
    else $error("direct cursor write lost");
  a_read_misc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && rd_i && indirect_i && index_i == cdcr_pkg::MISC_OUTPUT_CONTROL_IDX)
    |=> rdata_o == $past(misc_q))
    else $error("misc read data wrong");

  // Vertical blank run length
  a_vblank_short: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && !cci_q[cdcr_pkg::CCI_VBLANK_LEN_BIT] && !(blank_i && !blank_q)
     && (run_q + 13'h0001) == cdcr_pkg::VBLANK_SHORT_CYC) |=> vblank_o)
    else $error("short vblank missed");
  a_vblank_long: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cci_q[cdcr_pkg::CCI_VBLANK_LEN_BIT] && !(blank_i && !blank_q)
     && (run_q + 13'h0001) == cdcr_pkg::VBLANK_LONG_CYC) |=> vblank_o)
    else $error("long vblank missed");

  // Clock enable hold
  a_enable_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !clk_en_i |=> $stable(misc_q) && $stable(cci_q) && $stable(ccd_q)
                  && $stable(rdata_o) && $stable(run_q) && $stable(vblank_o))
    else $error("state moved with enable low");

endmodule // cdcr_regs

// *** bench/test_cdcr_regs.sv ***
// Self-checking bench for the cursor and DAC control register bank
`timescale 1ns/100ps
`define CHK(n, e, s) check_count++; if ((e) !== (s)) begin n_mismatch++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end
module test_cdcr_regs;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        wr_i = 1'b0, rd_i = 1'b0, indirect_i = 1'b0, obs = 1'b0;
  logic        rd_seen = 1'b0, obs_q = 1'b0, colorkey_bypass_i = 1'b0;
  logic        pixel_port_sel_i = 1'b0, odd_even_i = 1'b0, blank_i = 1'b0;
  logic [3:0]  reg_sel_i = 4'h0;
  logic [7:0]  index_i = 8'h00, wdata_i = 8'h00, cursor_ram_addr_lo_i = 8'h00;
  logic [7:0]  mi = 8'h00, ci = 8'h00, di = 8'h00, rdata_o;
  logic [1:0]  cursor_mode_o;
  logic [9:0]  cursor_ram_addr_o;
  logic        bypass_sel_o, pixel_port_path_o, dac_8bit_o, dac_powerdown_o;
  logic        interlace_en_o, odd_field_o, vblank_o;
  wire  [17:0] got = {bypass_sel_o, pixel_port_path_o, dac_8bit_o, dac_powerdown_o,
                      cursor_mode_o, interlace_en_o, odd_field_o, cursor_ram_addr_o};
  logic [18:0] exp_q[$];
  logic [18:0] e;
  logic [31:0] r = 32'h9E5D;
  int          n_mismatch = 0, check_count = 0;
  cdcr_regs i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .wr_i(wr_i),
    .rd_i(rd_i), .indirect_i(indirect_i), .reg_sel_i(reg_sel_i), .index_i(index_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .colorkey_bypass_i(colorkey_bypass_i),
    .pixel_port_sel_i(pixel_port_sel_i), .odd_even_i(odd_even_i), .blank_i(blank_i),
    .cursor_ram_addr_lo_i(cursor_ram_addr_lo_i), .bypass_sel_o(bypass_sel_o),
    .pixel_port_path_o(pixel_port_path_o), .dac_8bit_o(dac_8bit_o),
    .dac_powerdown_o(dac_powerdown_o), .cursor_mode_o(cursor_mode_o),
    .interlace_en_o(interlace_en_o), .odd_field_o(odd_field_o),
    .cursor_ram_addr_o(cursor_ram_addr_o), .vblank_o(vblank_o));
  always #20 clk_sys_i = ~clk_sys_i;
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [18:0] ctl(input logic vb);
    logic       by;
    logic [1:0] m;
    by = mi[5] | colorkey_bypass_i;
    m = ci[7] ? di[1:0] : ci[1:0];
    return {vb, by, pixel_port_sel_i & ~by, mi[3], mi[0], m, ci[5], odd_even_i ^ ci[6],
            ci[3:2], cursor_ram_addr_lo_i};
  endfunction
  // One host cycle from falling edge to falling edge; strobes stay up until look drops them
  task acc(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
    wr_i = w;
    rd_i = !w;
    indirect_i = ind;
    index_i = a;
    reg_sel_i = a[3:0];
    wdata_i = d;
    @(negedge clk_sys_i);
  endtask
  task wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
    if (ind && a == cdcr_pkg::CURSOR_CONTROL_INDIRECT_IDX) ci = d;
    if (ind && a == cdcr_pkg::MISC_OUTPUT_CONTROL_IDX) mi = d & cdcr_pkg::MISC_WRITE_MASK;
    if (!ind && a[3:0] == cdcr_pkg::CURSOR_CONTROL_DIRECT_SEL)
      di = d & cdcr_pkg::DIRECT_WRITE_MASK;
    acc(1'b1, ind, a, d);
  endtask
  task rd(input logic ind, input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back({11'h000, x});
    acc(1'b0, ind, a, 8'h00);
  endtask
  // Controls settle two edges after a write, so allow three before looking
  task look(input logic vb);
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    exp_q.push_back(ctl(vb));
    obs = 1'b1;
    @(negedge clk_sys_i);
    obs = 1'b0;
  endtask
  always @(posedge clk_sys_i)
  begin
    rd_seen <= rd_i;
    obs_q <= obs;
  end
  always @(negedge clk_sys_i)
  begin
    if (rd_seen && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK("rdata", e[7:0], rdata_o)
    end
    if (obs_q && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK("vblank", e[18], vblank_o)
      `CHK("dac", e[17:14], got[17:14])
      `CHK("cursor", e[13:0], got[13:0])
    end
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd(1'b1, 8'h1E, 8'h00);
    rd(1'b1, 8'h06, 8'h00);
    rd(1'b0, 8'h09, 8'h00);
    rd(1'b1, 8'h55, 8'h00);
    look(1'b0);
    // Every cursor mode through both registers, other fields random
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      {colorkey_bypass_i, pixel_port_sel_i, odd_even_i} = r[10:8];
      cursor_ram_addr_lo_i = r[23:16];
      wr(1'b1, 8'h1E, r[7:0]);
      wr(1'b1, 8'h06, {i[2], r[30:26], i[1:0]});
      wr(1'b0, 8'h09, {r[15:10], ~i[1:0]});
      wr(1'b1, 8'h77, r[7:0]);
      rd(1'b1, 8'h1E, mi);
      rd(1'b1, 8'h06, ci);
      rd(1'b0, 8'h09, di);
      look(1'b0);
    end
    // Enable low: writes must not land and every output must hold
    clk_en_i = 1'b0;
    acc(1'b1, 1'b1, 8'h1E, ~mi);
    acc(1'b1, 1'b0, 8'h09, ~di);
    look(1'b0);
    clk_en_i = 1'b1;
    rd(1'b1, 8'h1E, mi);
    rd(1'b0, 8'h09, di);
    look(1'b0);
    // Reset in mid-run brings every register back to zero
    rst_i = 1'b1;
    {mi, ci, di} = 24'h000000;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd(1'b1, 8'h1E, mi);
    rd(1'b1, 8'h06, ci);
    rd(1'b0, 8'h09, di);
    look(1'b0);
    // Vertical blank after a long run with no blank rising edge
    for (int l = 0; l < 2; l++)
    begin
      wr(1'b1, 8'h06, {3'h0, l[0], 4'h0});
      wr_i = 1'b0;
      blank_i = 1'b0;
      @(negedge clk_sys_i);
      blank_i = 1'b1;
      repeat ((l ? 4096 : 2048) - 12) @(negedge clk_sys_i);
      look(1'b0);
      repeat (20) @(negedge clk_sys_i);
      look(1'b1);
    end
    repeat (3) @(negedge clk_sys_i);
    stop_test;
  end
  initial
  begin
    repeat (20000) @(negedge clk_sys_i);
    n_mismatch++;
    stop_test;
  end
endmodule // test_cdcr_regs
